// >>> standby_pkg.sv
package standby_pkg;
    // register indices on the plain port
    localparam logic [3:0] ADR_KEY_OUT   = 4'h0;
    localparam logic [3:0] ADR_KEY_IN    = 4'h1;
    localparam logic [3:0] ADR_SENSE_CFG = 4'h2;
    localparam logic [3:0] ADR_CTRL      = 4'h3;
    localparam logic [3:0] ADR_STATUS    = 4'h4;
    localparam logic [3:0] ADR_OPTION    = 4'h5;
    // reset values
    localparam logic [7:0]  KEY_OUT_RST   = 8'hff;
    localparam logic [7:0]  SENSE_CFG_RST = 8'h26;
    localparam logic [7:0]  KEY_IN_FIXED  = 8'h0d;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [11:0] PC_RST        = 12'h000;
    localparam logic [11:0] DP_RST        = 12'h000;
    localparam logic [9:0]  TIMER_RST     = 10'h000;
    localparam int KEY_IN_S2_BIT = 1;
    localparam int CTRL_RET_BIT  = 3;
    // sense enables in the sense configuration port
    localparam int SENSE0_EN_BIT = 0;
    localparam int SENSE1_EN_BIT = 2;
    localparam int SENSE2_EN_BIT = 3;
    // post-stop wait, in oscillator periods and clock cycles
    localparam int FX_PERIOD_NS   = 250;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int WAIT_NORM_FX   = 284;
    localparam int WAIT_FAST_FX   = 270;
    localparam int WAIT_NORM_CYC  = (WAIT_NORM_FX * FX_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int WAIT_FAST_CYC  = (WAIT_FAST_FX * FX_PERIOD_NS) / CLK_PERIOD_NS;
    typedef enum logic [4:0] {
        ST_ACTIVE = 5'b00001,
        ST_HALTED = 5'b00010,
        ST_DEFER  = 5'b00100,
        ST_STOPPED = 5'b01000,
        ST_WAKE   = 5'b10000
    } mode_t;
    typedef enum logic [1:0] {
        OP_STOP_ALL = 2'h0,
        OP_STOP_K0  = 2'h1,
        OP_HALT     = 2'h2,
        OP_ILLEGAL  = 2'h3
    } op_kind_t;
    typedef struct packed {
        logic [3:0] key;
        logic [2:0] sense;
        logic       poc_n;
        logic       ret_low;
    } pins_t;
endpackage

// >>> standby_wake_reset_control.sv
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (RULE_01) standby entered only by the standby op with 4-bit operand and flag clear
// (RULE_02) leaving standby by wake or power-on clear sets the wake flag
// (RULE_03) op with flag set stays active; flag becomes current wake condition
// (RULE_04) wake condition already true at the op: no standby, flag set
// (RULE_05) reset restarts at address 0; wake resumes at the next address
// (RULE_06) stop patterns 000/011 need all scan outputs high, 110 only output 0
// (RULE_07) operand bit 3 adds enabled sense pins as stop wake sources
// (RULE_08) pattern 101 halts with no precondition; wakes at timer zero
// (RULE_09) illegal operand or failed precondition raises system reset
// (RULE_10) stop waits for timer count and output enable both zero
// (RULE_11) software puts a no-operation op first after stop
// (RULE_12) stop wake waits 284 or 270 fx periods plus growth time
// (RULE_13) wake gone at end of wait returns to stop; input must hold
// (RULE_14) reset on power-on clear, illegal standby, rotate-zero with a=0, stack fault
// (RULE_15) reset clears pc, data pointer, stack pointer, carry and timer; flag too, unless power-on clear ends standby
// (RULE_16) reset loads key-out ff, sense config 26, key-in xxxx11x1 from pins
// (RULE_17) reset loads control 0000x000, x is inverted retention-low detection
// (RULE_18) board holds a key input low at power-on clear release
// (RULE_19) halt stops execution, oscillator and timer keep running
// (RULE_20) stop halts oscillator, clears timer, keeps memory and ports
// (RULE_21) wake pins seen combinationally, then synchronized before use
module standby_wake_reset_control #(
    parameter int GROWTH_CYCLES = 40
) (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [7:0]  REG_RDATA,
    // instruction events from the core
    input  wire logic        STANDBY_OP,
    input  wire logic [3:0]  STANDBY_OPERAND,
    input  wire logic        ROTATE_ZERO_OP,
    input  wire logic        ACC_IS_ZERO,
    input  wire logic        STACK_FAULT,
    // timer status
    input  wire logic [9:0]  TIMER_COUNT,
    input  wire logic        TIMER_OUT_EN,
    // pins
    input  wire logic [3:0]  KEY_INPUT_PINS,
    input  wire logic        SENSE_PIN_ZERO,
    input  wire logic        SENSE_PIN_ONE,
    input  wire logic        SENSE_PIN_TWO,
    input  wire logic        POWER_ON_CLEAR_N,
    input  wire logic        RETENTION_LOW,
    // core control
    output var  logic        CPU_RUN,
    output var  logic        SYS_RESET,
    output var  logic        RESUME_NEXT,
    output var  logic        OSC_STOP,
    output var  logic        OSC_RESTART,
    output var  logic        TIMER_CLEAR,
    output var  logic        WAKE_FLAG,
    output var  logic [11:0] PC_RESET_VALUE,
    output var  logic [11:0] DP_RESET_VALUE,
    output var  logic [9:0]  TIMER_RESET_VALUE,
    // port registers
    output var  logic [7:0]  KEY_SCAN_OUT,
    output var  logic [7:0]  SENSE_CFG
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        standby_pkg::mode_t mode;
        logic               flag;
        logic [3:0]         operand;
        logic [11:0]        cnt;
        logic [7:0]         key_out;
        logic [7:0]         key_in;
        logic [7:0]         sense_cfg;
        logic [7:0]         ctrl;
        logic               fast;
        logic               reset_p;
        logic               resume_p;
        logic [7:0]         rdata;
        standby_pkg::pins_t sync1;
        standby_pkg::pins_t sync2;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    function automatic standby_pkg::op_kind_t op_kind(input logic [3:0] op);
        case (op[2:0])
            3'h0, 3'h3: op_kind = standby_pkg::OP_STOP_ALL; // RULE_06
            3'h6:       op_kind = standby_pkg::OP_STOP_K0;  // RULE_06
            3'h5:       op_kind = standby_pkg::OP_HALT;     // RULE_08
            default:    op_kind = standby_pkg::OP_ILLEGAL;  // RULE_09
        endcase
    endfunction

    function automatic logic wake_cond(input logic [3:0] op, input standby_pkg::pins_t p,
                                       input logic [7:0] cfg, input logic tzero);
        logic sense_any;
        sense_any = (p.sense[0] & cfg[standby_pkg::SENSE0_EN_BIT])
                  | (p.sense[1] & cfg[standby_pkg::SENSE1_EN_BIT])
                  | (p.sense[2] & cfg[standby_pkg::SENSE2_EN_BIT]);
        if (op_kind(op) == standby_pkg::OP_HALT)
            wake_cond = tzero;                       // RULE_08
        else
            wake_cond = (|p.key) | (op[3] & sense_any); // RULE_07
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    standby_pkg::pins_t raw_pins;
    logic               timer_zero;
    logic               timer_idle;
    logic               wake_now;
    logic               precond_ok;
    logic               fault;
    logic [11:0]        wait_load;

    assign raw_pins = '{key: KEY_INPUT_PINS,
                        sense: {SENSE_PIN_TWO, SENSE_PIN_ONE, SENSE_PIN_ZERO},
                        poc_n: POWER_ON_CLEAR_N, ret_low: RETENTION_LOW};
    assign timer_zero = (TIMER_COUNT == standby_pkg::TIMER_RST);
    assign timer_idle = timer_zero & ~TIMER_OUT_EN;
    assign wait_load  = cur_ff.fast
                      ? 12'(standby_pkg::WAIT_FAST_CYC + GROWTH_CYCLES)
                      : 12'(standby_pkg::WAIT_NORM_CYC + GROWTH_CYCLES); // RULE_12

    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.sync1 = raw_pins;      // RULE_21
        nxt_ff.sync2 = cur_ff.sync1;  // RULE_21
        nxt_ff.reset_p = 1'b0;
        nxt_ff.resume_p = 1'b0;
        nxt_ff.rdata = 8'h00;
        wake_now = wake_cond(cur_ff.operand, cur_ff.sync2, cur_ff.sense_cfg, timer_zero);
        precond_ok = 1'b1;
        fault = 1'b0;

        // register port
        if (REG_WR && REG_ADDR == standby_pkg::ADR_KEY_OUT)
            nxt_ff.key_out = REG_WDATA;
        else if (REG_WR && REG_ADDR == standby_pkg::ADR_SENSE_CFG)
            nxt_ff.sense_cfg = REG_WDATA;
        else if (REG_WR && REG_ADDR == standby_pkg::ADR_CTRL)
            nxt_ff.ctrl = REG_WDATA;
        else if (REG_WR && REG_ADDR == standby_pkg::ADR_OPTION)
            nxt_ff.fast = REG_WDATA[0];
        if (REG_RD && REG_ADDR == standby_pkg::ADR_KEY_OUT)
            nxt_ff.rdata = cur_ff.key_out;
        else if (REG_RD && REG_ADDR == standby_pkg::ADR_KEY_IN)
            nxt_ff.rdata = cur_ff.key_in;
        else if (REG_RD && REG_ADDR == standby_pkg::ADR_SENSE_CFG)
            nxt_ff.rdata = cur_ff.sense_cfg;
        else if (REG_RD && REG_ADDR == standby_pkg::ADR_CTRL)
            nxt_ff.rdata = cur_ff.ctrl;
        else if (REG_RD && REG_ADDR == standby_pkg::ADR_STATUS)
            nxt_ff.rdata = {2'h0, cur_ff.mode, cur_ff.flag};
        else if (REG_RD && REG_ADDR == standby_pkg::ADR_OPTION)
            nxt_ff.rdata = {7'h00, cur_ff.fast};

        // ----------------------------------------
        // standby sequencing
        // ----------------------------------------
        case (cur_ff.mode)
            standby_pkg::ST_ACTIVE:
            begin
                if (STANDBY_OP)
                begin
                    nxt_ff.operand = STANDBY_OPERAND;
                    wake_now = wake_cond(STANDBY_OPERAND, cur_ff.sync2,
                                         cur_ff.sense_cfg, timer_zero);
                    if (op_kind(STANDBY_OPERAND) == standby_pkg::OP_STOP_ALL)
                        precond_ok = &cur_ff.key_out;               // RULE_06
                    else if (op_kind(STANDBY_OPERAND) == standby_pkg::OP_STOP_K0)
                        precond_ok = cur_ff.key_out[0];             // RULE_06
                    if (op_kind(STANDBY_OPERAND) == standby_pkg::OP_ILLEGAL || !precond_ok)
                        fault = 1'b1;                               // RULE_09
                    else if (cur_ff.flag)
                        nxt_ff.flag = wake_now;                     // RULE_03
                    else if (wake_now)
                        nxt_ff.flag = 1'b1;                         // RULE_04
                    else if (op_kind(STANDBY_OPERAND) == standby_pkg::OP_HALT)
                        nxt_ff.mode = standby_pkg::ST_HALTED;       // RULE_01
                    else if (timer_idle)
                        nxt_ff.mode = standby_pkg::ST_STOPPED;      // RULE_01
                    else
                        nxt_ff.mode = standby_pkg::ST_DEFER;        // RULE_10
                end
            end
            standby_pkg::ST_HALTED:
            begin
                if (wake_now)
                begin
                    nxt_ff.mode = standby_pkg::ST_ACTIVE;
                    nxt_ff.flag = 1'b1;      // RULE_02
                    nxt_ff.resume_p = 1'b1;  // RULE_05
                end
            end
            standby_pkg::ST_DEFER:
            begin
                if (timer_idle)
                    nxt_ff.mode = standby_pkg::ST_STOPPED; // RULE_10
            end
            standby_pkg::ST_STOPPED:
            begin
                if (wake_now)
                begin
                    nxt_ff.mode = standby_pkg::ST_WAKE;
                    nxt_ff.cnt = wait_load;  // RULE_12
                end
            end
            standby_pkg::ST_WAKE:
            begin
                if (cur_ff.cnt != 12'h000)
                    nxt_ff.cnt = cur_ff.cnt - 12'h001;
                else if (wake_now)
                begin
                    nxt_ff.mode = standby_pkg::ST_ACTIVE;
                    nxt_ff.flag = 1'b1;      // RULE_02
                    nxt_ff.resume_p = 1'b1;  // RULE_05
                end
                else
                    nxt_ff.mode = standby_pkg::ST_STOPPED; // RULE_13
            end
            default:
                nxt_ff.mode = standby_pkg::ST_ACTIVE;
        endcase

        // ----------------------------------------
        // system reset causes
        // ----------------------------------------
        if (cur_ff.mode == standby_pkg::ST_ACTIVE && ((ROTATE_ZERO_OP && ACC_IS_ZERO) || STACK_FAULT))
            fault = 1'b1;                                           // RULE_14
        if (!cur_ff.sync2.poc_n || fault)
        begin
            nxt_ff.reset_p   = 1'b1;                                // RULE_14
            nxt_ff.resume_p  = 1'b0;
            nxt_ff.mode      = standby_pkg::ST_ACTIVE;              // RULE_05
            nxt_ff.flag      = !cur_ff.sync2.poc_n && cur_ff.mode != standby_pkg::ST_ACTIVE; // RULE_02
            nxt_ff.cnt       = 12'h000;
            nxt_ff.key_out   = standby_pkg::KEY_OUT_RST;            // RULE_16
            nxt_ff.sense_cfg = standby_pkg::SENSE_CFG_RST;          // RULE_16
            nxt_ff.key_in    = standby_pkg::KEY_IN_FIXED;           // RULE_16
            nxt_ff.key_in[7:4] = cur_ff.sync2.key;                  // RULE_16
            nxt_ff.key_in[standby_pkg::KEY_IN_S2_BIT] = cur_ff.sync2.sense[2];
            nxt_ff.ctrl      = standby_pkg::CTRL_RST;               // RULE_17
            nxt_ff.ctrl[standby_pkg::CTRL_RET_BIT] = ~cur_ff.sync2.ret_low; // RULE_17
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            cur_ff           <= '0;
            cur_ff.mode      <= standby_pkg::ST_ACTIVE;
            cur_ff.key_out   <= standby_pkg::KEY_OUT_RST;
            cur_ff.sense_cfg <= standby_pkg::SENSE_CFG_RST;
            cur_ff.key_in    <= standby_pkg::KEY_IN_FIXED;
            cur_ff.ctrl      <= standby_pkg::CTRL_RST;
            cur_ff.sync1     <= '{key: 4'h0, sense: 3'h0, poc_n: 1'b1, ret_low: 1'b0};
            cur_ff.sync2     <= '{key: 4'h0, sense: 3'h0, poc_n: 1'b1, ret_low: 1'b0};
        end
        else
            cur_ff <= nxt_ff;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign REG_RDATA   = cur_ff.rdata;
    assign CPU_RUN     = cur_ff.mode == standby_pkg::ST_ACTIVE;   // RULE_19
    assign SYS_RESET   = cur_ff.reset_p;
    assign RESUME_NEXT = cur_ff.resume_p;
    assign OSC_STOP    = cur_ff.mode[3];                          // RULE_20
    assign TIMER_CLEAR = cur_ff.mode[3] | cur_ff.mode[4] | cur_ff.reset_p; // RULE_20
    assign WAKE_FLAG   = cur_ff.flag;
    assign PC_RESET_VALUE    = standby_pkg::PC_RST;               // RULE_15
    assign DP_RESET_VALUE    = standby_pkg::DP_RST;               // RULE_15
    assign TIMER_RESET_VALUE = standby_pkg::TIMER_RST;            // RULE_15
    assign KEY_SCAN_OUT = cur_ff.key_out;
    assign SENSE_CFG    = cur_ff.sense_cfg;
    // raw level asks the oscillator to restart while the clock is dead
    assign OSC_RESTART = cur_ff.mode[3] & wake_cond(cur_ff.operand, raw_pins,
                         cur_ff.sense_cfg, timer_zero); // RULE_21

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    illegal_op_reset_a: assert property ( // RULE_09
        cur_ff.mode == standby_pkg::ST_ACTIVE && STANDBY_OP && STANDBY_OPERAND[2:0] == 3'h1
        |=> SYS_RESET && CPU_RUN) else $error("illegal operand did not reset");
    rotate_zero_reset_a: assert property ( // RULE_14
        CPU_RUN && ROTATE_ZERO_OP && ACC_IS_ZERO |=> SYS_RESET) else $error("missing reset");
    flag_blocks_entry_a: assert property ( // RULE_03
        CPU_RUN && STANDBY_OP && WAKE_FLAG && !$past(SYS_RESET) && op_kind(STANDBY_OPERAND)
        != standby_pkg::OP_ILLEGAL |=> CPU_RUN) else $error("entered standby with flag set");
    halt_wake_flag_a: assert property ( // RULE_02
        cur_ff.mode == standby_pkg::ST_HALTED && timer_zero && cur_ff.sync2.poc_n
        |=> CPU_RUN && WAKE_FLAG && RESUME_NEXT) else $error("halt wake wrong");
    stop_defer_a: assert property ( // RULE_10
        $rose(OSC_STOP) |-> $past(TIMER_COUNT) == 10'h000 && !$past(TIMER_OUT_EN))
        else $error("stop entered with timer running");
    wait_len_a: assert property ( // RULE_12
        $rose(cur_ff.mode[4]) |-> !CPU_RUN [*8]) else $error("wake wait cut short");
    stop_reenter_a: assert property ( // RULE_13
        cur_ff.mode[4] && cur_ff.cnt == 12'h000 && !wake_now && cur_ff.sync2.poc_n
        |=> OSC_STOP) else $error("did not return to stop");
    reset_ports_a: assert property ( // RULE_16
        SYS_RESET |-> KEY_SCAN_OUT == standby_pkg::KEY_OUT_RST
        && SENSE_CFG == standby_pkg::SENSE_CFG_RST) else $error("port reset values wrong");
    reset_ctrl_a: assert property ( // RULE_17
        SYS_RESET |-> cur_ff.ctrl[standby_pkg::CTRL_RET_BIT] == !$past(cur_ff.sync2.ret_low))
        else $error("control reset bit wrong");

endmodule
`default_nettype wire

// >>> key_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// key matrix and sense switches, pulled down when released
// ------------------------------------------------------------
module key_switch_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // press command from the bench
    input  wire logic        press,
    input  wire logic [3:0]  keys,
    input  wire logic [2:0]  sense,
    input  wire logic [15:0] hold,
    // pins
    output var  logic [3:0]  key_pins,
    output var  logic [2:0]  sense_pins
);
    logic [15:0] left_ff;
    always_ff @(posedge clock)
    begin
        if (!rst_n || (left_ff == 16'h0001 && !press))
        begin
            key_pins   <= 4'h0;
            sense_pins <= 3'h0;
        end
        else if (press)
        begin
            key_pins   <= keys;
            sense_pins <= sense;
        end
        if (!rst_n)
            left_ff <= 16'h0000;
        else if (press)
            left_ff <= hold;
        else if (left_ff != 16'h0000)
            left_ff <= left_ff - 16'h0001;
    end
endmodule
`default_nettype wire

// >>> test_standby_wake_reset_control.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// self-checking bench for the standby and reset control
// ------------------------------------------------------------
module test_standby_wake_reset_control;
    localparam int GROWTH = 2;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        op = 1'b0;
    logic [3:0]  operand = 4'h0;
    logic        rot_op = 1'b0;
    logic        acc_zero = 1'b0;
    logic        stack_fault = 1'b0;
    logic [9:0]  timer_count = 10'h000;
    logic        timer_out_en = 1'b0;
    logic        poc_n = 1'b1;
    logic        ret_low = 1'b0;
    logic        press = 1'b0;
    logic [3:0]  press_keys = 4'h0;
    logic [2:0]  press_sense = 3'h0;
    logic [15:0] hold = 16'h0000;
    logic [3:0]  key_pins;
    logic [2:0]  sense_pins;
    logic        cpu_run, sys_reset, resume_next, osc_stop, osc_restart, timer_clear, wake_flag;
    logic [11:0] pc_rv, dp_rv;
    logic [9:0]  tm_rv;
    logic [7:0]  reg_rdata, key_scan_out, sense_cfg, rd, kv;
    logic [3:0]  bad_ops [8] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h9, 4'ha, 4'hc, 4'hf};
    logic [31:0] seed = 32'hd74cb8c4;
    int          bad_count = 0;
    int          n_checks = 0;
    int          n;

    always #12.5 clock = ~clock;

    key_switch_model i_key_switch_model (.clock(clock), .rst_n(rst_n), .press(press),
        .keys(press_keys), .sense(press_sense), .hold(hold), .key_pins(key_pins),
        .sense_pins(sense_pins));
    standby_wake_reset_control #(.GROWTH_CYCLES(GROWTH)) i_standby_wake_reset_control (
        .CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .STANDBY_OP(op),
        .STANDBY_OPERAND(operand), .ROTATE_ZERO_OP(rot_op), .ACC_IS_ZERO(acc_zero),
        .STACK_FAULT(stack_fault), .TIMER_COUNT(timer_count), .TIMER_OUT_EN(timer_out_en),
        .KEY_INPUT_PINS(key_pins), .SENSE_PIN_ZERO(sense_pins[0]),
        .SENSE_PIN_ONE(sense_pins[1]), .SENSE_PIN_TWO(sense_pins[2]),
        .POWER_ON_CLEAR_N(poc_n), .RETENTION_LOW(ret_low), .CPU_RUN(cpu_run),
        .SYS_RESET(sys_reset), .RESUME_NEXT(resume_next), .OSC_STOP(osc_stop),
        .OSC_RESTART(osc_restart), .TIMER_CLEAR(timer_clear), .WAKE_FLAG(wake_flag),
        .PC_RESET_VALUE(pc_rv), .DP_RESET_VALUE(dp_rv), .TIMER_RESET_VALUE(tm_rv),
        .KEY_SCAN_OUT(key_scan_out), .SENSE_CFG(sense_cfg));

    function automatic logic [7:0] rnd8();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [9:0] rnd_tc();
        return {2'b01, rnd8()};
    endfunction
    function automatic logic [7:0] key_in_exp(input logic [3:0] k, input logic s2);
        return {k, 1'b1, 1'b1, s2, 1'b1};
    endfunction
    function automatic int wake_span(input bit fast);
        return (fast ? standby_pkg::WAIT_FAST_CYC : standby_pkg::WAIT_NORM_CYC) + GROWTH + 4;
    endfunction
    task automatic miss(input string what);
        bad_count++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
            miss("status bit wrong");
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
            miss($sformatf("byte %h, wanted %h", got, exp));
    endtask
    task automatic chk_span(input int got, input int exp);
        n_checks++;
        if (got < exp - 2 || got > exp + 3)
            miss($sformatf("wake after %0d cycles, wanted near %0d", got, exp));
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        chk_byte(rd, exp);
    endtask
    task automatic do_op(input logic [3:0] v, input logic [9:0] tc);
        @(posedge clock);
        op          <= 1'b1;
        operand     <= v;
        timer_count <= tc;
        @(posedge clock);
        op <= 1'b0;
        #1;
    endtask
    task automatic cause(input logic stack, input logic accz);
        @(posedge clock);
        stack_fault <= stack;
        rot_op      <= !stack;
        acc_zero    <= accz;
        @(posedge clock);
        stack_fault <= 1'b0;
        rot_op      <= 1'b0;
        #1;
    endtask
    task automatic push(input logic [3:0] k, input logic [2:0] s, input logic [15:0] h);
        @(posedge clock);
        press       <= 1'b1;
        press_keys  <= k;
        press_sense <= s;
        hold        <= h;
        @(posedge clock);
        press <= 1'b0;
    endtask
    task automatic poc_blip();
        @(posedge clock);
        poc_n <= 1'b0;
        @(posedge clock);
        poc_n <= 1'b1;
        for (n = 0; sys_reset !== 1'b1 && n < 8; n++)
            tick(1);
        chk_bit(sys_reset, 1'b1);
        tick(6);
    endtask
    task automatic wake_check(input bit fast);
        for (n = 0; cpu_run !== 1'b1 && n < 4000; n++)
            tick(1);
        chk_span(n, wake_span(fast));
        chk_bit(wake_flag & resume_next, 1'b1);
        tick(100);
    endtask
    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        miss("watchdog expired");
        give_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        tick(1);
        chk_byte(key_scan_out, 8'hff);
        chk_byte(sense_cfg, 8'h26);
        chk_bit(pc_rv == 12'h000 && dp_rv == 12'h000 && tm_rv == 10'h000, 1'b1);
        rd_chk(standby_pkg::ADR_KEY_IN, key_in_exp(4'h0, 1'b0));
        rd_chk(standby_pkg::ADR_CTRL, 8'h00);
        rd_chk(standby_pkg::ADR_STATUS, 8'h02);
        reg_write(standby_pkg::ADR_KEY_IN, rnd8());
        rd_chk(standby_pkg::ADR_KEY_IN, 8'h0d);
        rd_chk(4'hf, 8'h00);
        end_test("reset values");
        do_op(4'h5, rnd_tc());
        tick(20);
        chk_bit(cpu_run | osc_stop | timer_clear, 1'b0);
        @(posedge clock);
        timer_count <= 10'h000;
        tick(1);
        chk_bit(cpu_run & wake_flag & resume_next, 1'b1);
        do_op(4'hd, rnd_tc());
        chk_bit(cpu_run & !wake_flag, 1'b1);
        do_op(4'hd, rnd_tc());
        chk_bit(cpu_run, 1'b0);
        do_op(4'h5, 10'h000);
        chk_bit(cpu_run & wake_flag, 1'b1);
        do_op(4'h5, rnd_tc());
        do_op(4'h5, 10'h000);
        chk_bit(cpu_run & wake_flag & !resume_next, 1'b1);
        end_test("halt");
        foreach (bad_ops[i])
        begin
            reg_write(standby_pkg::ADR_KEY_OUT, rnd8());
            do_op(bad_ops[i], 10'h000);
            chk_bit(sys_reset & !wake_flag & !resume_next, 1'b1);
            tick(1);
            chk_byte(key_scan_out, 8'hff);
        end
        for (int i = 0; i < 2; i++)
        begin
            reg_write(standby_pkg::ADR_KEY_OUT, (rnd8() | 8'h01) & 8'h7f);
            do_op(i == 0 ? 4'h0 : 4'h3, 10'h000);
            chk_bit(sys_reset, 1'b1);
        end
        kv = (rnd8() | 8'h01) & 8'h7f;
        reg_write(standby_pkg::ADR_KEY_OUT, kv);
        do_op(4'h6, 10'h000);
        chk_bit(osc_stop & timer_clear & !cpu_run, 1'b1);
        push(4'h4, 3'h0, 16'd2900);
        wake_check(1'b0);
        chk_byte(key_scan_out, kv);
        end_test("stop by key");
        reg_write(standby_pkg::ADR_OPTION, 8'h01);
        do_op(4'h5, rnd_tc());
        do_op(4'h6, 10'h000);
        push(4'h1, 3'h0, 16'd20);
        tick(2);
        chk_bit(osc_restart, 1'b1);
        tick(98);
        chk_bit(osc_stop | cpu_run | !timer_clear, 1'b0);
        tick(2800);
        chk_bit(osc_stop & !cpu_run, 1'b1);
        poc_blip();
        chk_bit(wake_flag & cpu_run & !osc_stop, 1'b1);
        end_test("short press and power-on clear");
        reg_write(standby_pkg::ADR_OPTION, 8'h01);
        do_op(4'h5, rnd_tc());
        do_op(4'h8, 10'h000);
        push(4'h0, 3'h1, 16'd50);
        tick(60);
        chk_bit(osc_stop, 1'b1);
        push(4'h0, 3'h2, 16'd2800);
        wake_check(1'b1);
        end_test("sense wake");
        do_op(4'h5, rnd_tc());
        @(posedge clock);
        timer_out_en <= 1'b1;
        do_op(4'h3, rnd_tc());
        chk_bit(cpu_run | osc_stop, 1'b0);
        @(posedge clock);
        timer_count <= 10'h000;
        tick(4);
        chk_bit(osc_stop, 1'b0);
        @(posedge clock);
        timer_out_en <= 1'b0;
        tick(4);
        chk_bit(osc_stop, 1'b1);
        poc_blip();
        end_test("deferred stop");
        @(posedge clock);
        ret_low <= 1'b1;
        cause(1'b0, 1'b0);
        chk_bit(sys_reset | !wake_flag, 1'b0);
        tick(3);
        cause(1'b0, 1'b1);
        chk_bit(sys_reset & !wake_flag, 1'b1);
        rd_chk(standby_pkg::ADR_CTRL, 8'h00);
        @(posedge clock);
        ret_low <= 1'b0;
        push(4'ha, 3'h4, 16'd40);
        tick(5);
        cause(1'b1, 1'b0);
        chk_bit(sys_reset, 1'b1);
        rd_chk(standby_pkg::ADR_KEY_IN, key_in_exp(4'ha, 1'b1));
        rd_chk(standby_pkg::ADR_CTRL, 8'h08);
        end_test("reset causes");
        give_verdict();
    end
endmodule
`default_nettype wire
